// ===== verilog/dci_core.v
// Instruction decode and single-cycle execution core
//
// Operation
// - One 24-bit word fetched and executed every instruction cycle.
// - Each word decoded into move, compute, multifunction, flow or misc group.
// - Multifunction does one computation plus one or two data moves together.
// - X minus Y, borrow form adds carry minus one.
// - Y minus X, borrow form adds carry minus one.
// - Multifunction accepts any arithmetic operation except divide steps.
// - Shift-immediate carries an 8-bit two's-complement exponent.
// - Multifunction accepts any shifter operation except shift-immediate.
// - Indirect access addresses by index pointer, updated by the modifier that the modify field selects.
// - Program memory data indirect only; data memory direct or indirect.
// - Jump or call on true or inverted flag input pin.
// - Loop repeats to end address until encoded termination is true.
// - Conditional instructions execute only when their condition is true.
// - Optionally conditional interrupt return, separate from subroutine return.
// - Wait with divisor 16/32/64/128 slows clocks and waits for interrupt.
`timescale 1ns/100ps
module dci_core #(
  parameter DW = 16,
  parameter AW = 14
) (
  input  wire          clk_in,
  input  wire          rst_n_in,
  input  wire [23:0]   instr_in,
  input  wire [DW-1:0] dm_rdata_in,
  input  wire [23:0]   pm_rdata_in,
  input  wire          flag_pin_in,
  input  wire          irq_in,
  input  wire [AW-1:0] irq_vector_in,
  input  wire [DW-1:0] xop_in,
  input  wire [DW-1:0] yop_in,
  output reg  [AW-1:0] pc_out,
  output reg  [AW-1:0] dm_addr_out,
  output reg  [DW-1:0] dm_wdata_out,
  output reg           dm_rd_out,
  output reg           dm_wr_out,
  output reg  [AW-1:0] pm_addr_out,
  output reg  [23:0]   pm_wdata_out,
  output reg           pm_rd_out,
  output reg           pm_wr_out,
  output reg  [DW-1:0] alu_result_reg_out,
  output reg  [DW-1:0] alu_feedback_reg_out,
  output reg  [DW-1:0] shift_result_out,
  output reg  [2:0]    group_out,
  output reg           illegal_out,
  output reg           idle_out,
  output reg           slow_tick_out
);
`include "dci_core_map.vh"
  // ==========================================================
  // Field extraction
  wire [2:0]    grp   = instr_in[`DCI_GRP_HI:`DCI_GRP_LO];
  wire [3:0]    op    = instr_in[`DCI_OP_HI:`DCI_OP_LO];
  wire [3:0]    cc    = instr_in[`DCI_COND_HI:`DCI_COND_LO];
  wire [1:0]    isel  = instr_in[`DCI_IDX_HI:`DCI_IDX_LO];
  wire [1:0]    msel  = instr_in[`DCI_MOD_HI:`DCI_MOD_LO];
  wire          cy    = instr_in[`DCI_CARRY_BIT];
  wire [AW-1:0] iaddr = instr_in[`DCI_ADDR_HI:`DCI_ADDR_LO];
  wire [7:0]    sexp  = instr_in[`DCI_EXP_HI:`DCI_EXP_LO];

  // ==========================================================
  // State
  reg [AW-1:0] index_pointer_q [0:3];
  reg [AW-1:0] pointer_modifier_q [0:3];
  reg [AW-1:0] stack_q [0:`DCI_STK_DEPTH-1];
  reg [1:0]    sp_q;
  reg [AW-1:0] iret_q;
  reg [AW-1:0] loop_top_q;
  reg [AW-1:0] loop_end_q;
  reg [3:0]    loop_term_q;
  reg          loop_act_q;
  reg          az_q;
  reg          an_q;
  reg          ac_q;
  reg [7:0]    div_cnt_q;
  reg [7:0]    div_max_q;
  reg          flag_s1_q;
  reg          flag_s2_q;
  reg          irq_s1_q;
  reg          irq_s2_q;
  integer      k;

  // Condition evaluators: one for the instruction, one for loop exit
  wire cond_true;
  wire term_true;
  dci_cond_eval u_cond (
    .code_in  (cc),
    .zero_in  (az_q),
    .neg_in   (an_q),
    .carry_in (ac_q),
    .true_out (cond_true)
  );
  dci_cond_eval u_term (
    .code_in  (loop_term_q),
    .zero_in  (az_q),
    .neg_in   (an_q),
    .carry_in (ac_q),
    .true_out (term_true)
  );

  // ==========================================================
  // Arithmetic unit
  reg [DW:0]   alu_sum;
  reg          alu_ok;
  wire [DW:0]  cin = {{DW{1'b0}}, cy & ac_q};
  wire [DW:0]  bor = {{DW{1'b0}}, ~(cy & ac_q)};   // Borrow is C-1 when selected
  wire [DW:0]  xe  = {1'b0, xop_in};
  wire [DW:0]  ye  = {1'b0, yop_in};
  always @* begin
    alu_ok = 1'b1;
    case (op)
      `DCI_ALU_ADD:   alu_sum = xe + ye + cin;
      `DCI_ALU_XMY:   alu_sum = xe - ye - (cy ? bor : {(DW+1){1'b0}});
      `DCI_ALU_YMX:   alu_sum = ye - xe - (cy ? bor : {(DW+1){1'b0}});
      `DCI_ALU_AND:   alu_sum = xe & ye;
      `DCI_ALU_OR:    alu_sum = xe | ye;
      `DCI_ALU_XOR:   alu_sum = xe ^ ye;
      `DCI_ALU_PASS:  alu_sum = xe;
      `DCI_ALU_NEG:   alu_sum = {(DW+1){1'b0}} - xe;
      `DCI_ALU_NOT:   alu_sum = {1'b0, ~xop_in};
      `DCI_ALU_ABS:   alu_sum = xop_in[DW-1] ? ({(DW+1){1'b0}} - xe) : xe;
      `DCI_ALU_INC:   alu_sum = ye + {{DW{1'b0}}, 1'b1};
      `DCI_ALU_DEC:   alu_sum = ye - {{DW{1'b0}}, 1'b1};
      // Simplified divide steps: sign step and one quotient shift
      `DCI_ALU_DSTEP: alu_sum = {1'b0, yop_in ^ xop_in};
      `DCI_ALU_QSTEP: alu_sum = {1'b0, alu_feedback_reg_out[DW-2:0], ~alu_sum_sign(xop_in)};
      default: begin
        alu_sum = {(DW+1){1'b0}};
        alu_ok  = 1'b0;
      end
    endcase
  end

  function alu_sum_sign;
    input [DW-1:0] v;
    begin
      alu_sum_sign = v[DW-1];
    end
  endfunction

  // Shifter: immediate amount is a signed 8-bit exponent, else from yop
  wire [7:0]    shamt = (op == `DCI_SHF_IMM) ? sexp : yop_in[7:0];
  wire [7:0]    shmag = shamt[7] ? (8'h00 - shamt) : shamt;
  wire [DW-1:0] shv   = shamt[7] ? (xop_in >> shmag) : (xop_in << shmag);
  wire          is_shift = (op == `DCI_SHF_IMM) || (op == `DCI_SHF_REG);

  // Multifunction legality: no divide steps, no shift-immediate
  wire multi_bad = (op == `DCI_ALU_DSTEP) || (op == `DCI_ALU_QSTEP)
                 || (op == `DCI_SHF_IMM);

  // ==========================================================
  // Address generation
  wire [AW-1:0] ptr     = index_pointer_q[isel];
  wire [AW-1:0] ptr_upd = ptr + pointer_modifier_q[msel];
  wire          dir     = instr_in[`DCI_DIR_BIT];
  wire          wr      = instr_in[`DCI_WR_BIT];
  wire          pm_sel  = instr_in[`DCI_SRC_LO];

  // Interrupt and pin synchronised before use
  wire flag_v = flag_s2_q;
  wire irq_v  = irq_s2_q;

  // Wait divisor 16,32,64,128 from two bits
  function [7:0] wait_div;
    input [1:0] s;
    begin
      wait_div = 8'h10 << s;
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_s1_q <= 1'b0;
      flag_s2_q <= 1'b0;
      irq_s1_q  <= 1'b0;
      irq_s2_q  <= 1'b0;
    end else begin
      flag_s1_q <= flag_pin_in;
      flag_s2_q <= flag_s1_q;
      irq_s1_q  <= irq_in;
      irq_s2_q  <= irq_s1_q;
    end
  end

  // ==========================================================
  // Single-cycle execute: every word finishes before the next edge
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_out <= `DCI_PC_RST;
      dm_addr_out <= {AW{1'b0}};
      dm_wdata_out <= {DW{1'b0}};
      dm_rd_out <= 1'b0;
      dm_wr_out <= 1'b0;
      pm_addr_out <= {AW{1'b0}};
      pm_wdata_out <= 24'h00_0000;
      pm_rd_out <= 1'b0;
      pm_wr_out <= 1'b0;
      alu_result_reg_out <= {DW{1'b0}};
      alu_feedback_reg_out <= {DW{1'b0}};
      shift_result_out <= {DW{1'b0}};
      group_out <= `DCI_GRP_MISC;
      illegal_out <= 1'b0;
      idle_out <= 1'b0;
      slow_tick_out <= 1'b0;
      sp_q <= 2'h0;
      iret_q <= {AW{1'b0}};
      loop_top_q <= {AW{1'b0}};
      loop_end_q <= {AW{1'b0}};
      loop_term_q <= 4'h0;
      loop_act_q <= 1'b0;
      az_q <= 1'b0;
      an_q <= 1'b0;
      ac_q <= 1'b0;
      div_cnt_q <= 8'h00;
      div_max_q <= 8'h00;
      for (k = 0; k < 4; k = k + 1) begin
        index_pointer_q[k] <= {AW{1'b0}};
        pointer_modifier_q[k] <= {AW{1'b0}};
        stack_q[k] <= {AW{1'b0}};
      end
    end else if (idle_out) begin
      // Slowed clock: a tick every divisor cycles, wake on interrupt at a tick
      div_cnt_q <= (div_cnt_q >= div_max_q - 8'h01) ? 8'h00 : div_cnt_q + 8'h01;
      slow_tick_out <= (div_cnt_q >= div_max_q - 8'h01);
      if (irq_v && (div_cnt_q >= div_max_q - 8'h01)) begin
        idle_out <= 1'b0;
        iret_q <= pc_out;
        pc_out <= irq_vector_in;
      end
    end else begin
      dm_rd_out <= 1'b0;
      dm_wr_out <= 1'b0;
      pm_rd_out <= 1'b0;
      pm_wr_out <= 1'b0;
      slow_tick_out <= 1'b1;
      illegal_out <= 1'b0;
      group_out <= grp;
      pc_out <= pc_out + {{(AW-1){1'b0}}, 1'b1};
      // Loop back at the end address unless termination is met
      if (loop_act_q && pc_out == loop_end_q) begin
        if (term_true)
          loop_act_q <= 1'b0;
        else
          pc_out <= loop_top_q;
      end
      case (grp)
        `DCI_GRP_MOVE: begin
          if (pm_sel) begin
            // Program memory data: indirect only
            pm_addr_out <= ptr;
            pm_wr_out <= wr;
            pm_rd_out <= ~wr;
            pm_wdata_out <= {xop_in, 8'h00};
            index_pointer_q[isel] <= ptr_upd;
          end else begin
            dm_addr_out <= dir ? iaddr : ptr;
            dm_wr_out <= wr;
            dm_rd_out <= ~wr;
            dm_wdata_out <= xop_in;
            if (!dir)
              index_pointer_q[isel] <= ptr_upd;
          end
        end
        `DCI_GRP_COMP, `DCI_GRP_MULTI: begin
          if (grp == `DCI_GRP_MULTI && multi_bad) begin
            illegal_out <= 1'b1;
          end else if (cond_true || grp == `DCI_GRP_MULTI) begin
            if (is_shift) begin
              shift_result_out <= shv;
            end else if (alu_ok) begin
              if (instr_in[`DCI_DST_LO])
                alu_feedback_reg_out <= alu_sum[DW-1:0];
              else
                alu_result_reg_out <= alu_sum[DW-1:0];
              az_q <= (alu_sum[DW-1:0] == {DW{1'b0}});
              an_q <= alu_sum[DW-1];
              ac_q <= alu_sum[DW];
            end
            if (grp == `DCI_GRP_MULTI) begin
              // Data memory move, plus program memory read when selected, in the same cycle
              dm_addr_out <= ptr;
              dm_rd_out <= ~wr;
              dm_wr_out <= wr;
              dm_wdata_out <= alu_result_reg_out;
              index_pointer_q[isel] <= ptr_upd;
              if (instr_in[`DCI_SRC_HI]) begin
                pm_addr_out <= index_pointer_q[msel];
                pm_rd_out <= 1'b1;
                index_pointer_q[msel] <= index_pointer_q[msel]
                                       + pointer_modifier_q[msel];
              end
            end
          end
        end
        `DCI_GRP_FLOW: begin
          case (op)
            `DCI_FL_JUMP:   if (cond_true) pc_out <= iaddr;
            `DCI_FL_JUMPI:  if (cond_true) pc_out <= ptr;
            `DCI_FL_CALL, `DCI_FL_CALLI, `DCI_FL_FCALL: begin
              if ((op == `DCI_FL_FCALL) ? (flag_v ^ cc[0]) : cond_true) begin
                stack_q[sp_q] <= pc_out + {{(AW-1){1'b0}}, 1'b1};
                sp_q <= sp_q + 2'h1;
                pc_out <= (op == `DCI_FL_CALLI) ? ptr : iaddr;
              end
            end
            `DCI_FL_FJUMP:  if (flag_v ^ cc[0]) pc_out <= iaddr;
            `DCI_FL_SUBRET: begin
              if (cond_true) begin
                pc_out <= stack_q[sp_q - 2'h1];
                sp_q <= sp_q - 2'h1;
              end
            end
            `DCI_FL_IRET:   if (cond_true) pc_out <= iret_q;
            `DCI_FL_LOOP: begin
              loop_top_q <= pc_out + {{(AW-1){1'b0}}, 1'b1};
              loop_end_q <= iaddr;
              loop_term_q <= cc;
              loop_act_q <= 1'b1;
            end
            `DCI_FL_WAIT: begin
              idle_out <= 1'b1;
              div_max_q <= instr_in[`DCI_WR_BIT] ? wait_div(isel) : 8'h01;
              div_cnt_q <= 8'h00;
            end
            default: illegal_out <= 1'b1;
          endcase
        end
        `DCI_GRP_MISC: begin
          if (op == `DCI_MS_MODIFY)
            index_pointer_q[isel] <= ptr_upd;
          else if (op != `DCI_MS_NOP)
            pointer_modifier_q[isel] <= instr_in[`DCI_ADDR_HI:`DCI_ADDR_LO];
        end
        default: illegal_out <= 1'b1;
      endcase
    end
  end
endmodule // dci_core

// ===== verilog/dci_core_map.vh
// Constants for the instruction decode and execution core
`ifndef DCI_CORE_MAP_VH
`define DCI_CORE_MAP_VH
// Instruction word and field positions
`define DCI_IW_W        24
`define DCI_GRP_HI      23
`define DCI_GRP_LO      21
`define DCI_OP_HI       20
`define DCI_OP_LO       17
`define DCI_COND_HI     16
`define DCI_COND_LO     13
`define DCI_IDX_HI      12
`define DCI_IDX_LO      11
`define DCI_MOD_HI      10
`define DCI_MOD_LO      9
`define DCI_DIR_BIT     8
`define DCI_WR_BIT      7
`define DCI_DST_HI      6
`define DCI_DST_LO      4
`define DCI_SRC_HI      3
`define DCI_SRC_LO      1
`define DCI_CARRY_BIT   0
`define DCI_ADDR_HI     13
`define DCI_ADDR_LO     0
`define DCI_EXP_HI      7
`define DCI_EXP_LO      0
`define DCI_IMM_HI      19
`define DCI_IMM_LO      4
// Instruction groups
`define DCI_GRP_MOVE    3'h0
`define DCI_GRP_COMP    3'h1
`define DCI_GRP_MULTI   3'h2
`define DCI_GRP_FLOW    3'h3
`define DCI_GRP_MISC    3'h4
// Arithmetic and shifter operations
`define DCI_ALU_ADD     4'h0
`define DCI_ALU_XMY     4'h1
`define DCI_ALU_YMX     4'h2
`define DCI_ALU_AND     4'h3
`define DCI_ALU_OR      4'h4
`define DCI_ALU_XOR     4'h5
`define DCI_ALU_PASS    4'h6
`define DCI_ALU_NEG     4'h7
`define DCI_ALU_NOT     4'h8
`define DCI_ALU_ABS     4'h9
`define DCI_ALU_INC     4'hA
`define DCI_ALU_DEC     4'hB
`define DCI_ALU_DSTEP   4'hC
`define DCI_ALU_QSTEP   4'hD
`define DCI_SHF_IMM     4'hE
`define DCI_SHF_REG     4'hF
// Flow operations
`define DCI_FL_JUMP     4'h0
`define DCI_FL_CALL     4'h1
`define DCI_FL_JUMPI    4'h2
`define DCI_FL_CALLI    4'h3
`define DCI_FL_FJUMP    4'h4
`define DCI_FL_FCALL    4'h5
`define DCI_FL_SUBRET   4'h6
`define DCI_FL_IRET     4'h7
`define DCI_FL_LOOP     4'h8
`define DCI_FL_WAIT     4'h9
// Miscellaneous operations
`define DCI_MS_NOP      4'h0
`define DCI_MS_MODIFY   4'h1
// Condition codes
`define DCI_CC_EQ       4'h0
`define DCI_CC_NE       4'h1
`define DCI_CC_LT       4'h2
`define DCI_CC_GE       4'h3
`define DCI_CC_CS       4'h4
`define DCI_CC_CC       4'h5
`define DCI_CC_NEVER    4'hE
`define DCI_CC_ALWAYS   4'hF
// Reset value and stack depth
`define DCI_PC_RST      14'h0000
`define DCI_STK_DEPTH   4
`endif

// ===== verilog/dci_cond_eval.v
// Condition code evaluator for conditional instructions and loop terminations
`timescale 1ns/100ps
module dci_cond_eval (
  input  wire [3:0] code_in,
  input  wire       zero_in,
  input  wire       neg_in,
  input  wire       carry_in,
  output reg        true_out
);
`include "dci_core_map.vh"
  // Pure decode, no state
  always @* begin
    case (code_in)
      `DCI_CC_EQ:     true_out = zero_in;
      `DCI_CC_NE:     true_out = ~zero_in;
      `DCI_CC_LT:     true_out = neg_in;
      `DCI_CC_GE:     true_out = ~neg_in;
      `DCI_CC_CS:     true_out = carry_in;
      `DCI_CC_CC:     true_out = ~carry_in;
      `DCI_CC_NEVER:  true_out = 1'b0;
      default:        true_out = 1'b1;
    endcase
  end
endmodule // dci_cond_eval

// ===== tb/dci_core_properties.sv
// Concurrent checks on the ports of the instruction core
`timescale 1ns/100ps
module dci_core_properties #(
  parameter DW = 16,
  parameter AW = 14
) (
  input wire          clk_in,
  input wire          rst_n_in,
  input wire [23:0]   instr_in,
  input wire [DW-1:0] dm_rdata_in,
  input wire [23:0]   pm_rdata_in,
  input wire          flag_pin_in,
  input wire          irq_in,
  input wire [AW-1:0] irq_vector_in,
  input wire [DW-1:0] xop_in,
  input wire [DW-1:0] yop_in,
  input wire [AW-1:0] pc_out,
  input wire [AW-1:0] dm_addr_out,
  input wire [DW-1:0] dm_wdata_out,
  input wire          dm_rd_out,
  input wire          dm_wr_out,
  input wire [AW-1:0] pm_addr_out,
  input wire [23:0]   pm_wdata_out,
  input wire          pm_rd_out,
  input wire          pm_wr_out,
  input wire [DW-1:0] alu_result_reg_out,
  input wire [DW-1:0] alu_feedback_reg_out,
  input wire [DW-1:0] shift_result_out,
  input wire [2:0]    group_out,
  input wire          illegal_out,
  input wire          idle_out,
  input wire          slow_tick_out
);
  // ==========================================
  // Decoded fields of the word on the bus
  wire [2:0] grp_w = instr_in[23:21];
  wire [3:0] op_w  = instr_in[20:17];
  wire [3:0] cc_w  = instr_in[16:13];
  wire       run_w = !idle_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Flag pin must settle through the synchroniser before a branch trusts it
  sequence s_flag_steady;
    $stable(flag_pin_in) [*3];
  endsequence
  sequence s_flag_branch;
    run_w && grp_w == 3'h3 && (op_w == 4'h4 || op_w == 4'h5);
  endsequence
  sequence s_sleep_irq;
    idle_out && irq_in;
  endsequence
  // ==========================================
  // Assertions
  chk_pc_advance: assert property (run_w && grp_w inside {3'h0, 3'h1, 3'h4} |=>
    pc_out == $past(pc_out) + 14'h0001) else $error("pc did not step by one");
  chk_group_track: assert property (run_w && grp_w <= 3'h4 |=>
    group_out == $past(grp_w)) else $error("group does not follow word");
  chk_jump_target: assert property (run_w && grp_w == 3'h3 && op_w == 4'h0
    && cc_w == 4'hf |=> pc_out == $past(instr_in[13:0])) else $error("jump target wrong");
  chk_flag_branch: assert property (s_flag_steady ##0 s_flag_branch |=> pc_out ==
    ($past(flag_pin_in ^ instr_in[13]) ? $past(instr_in[13:0]) : $past(pc_out) + 14'h0001))
    else $error("flag branch wrong");
  chk_sub_xy: assert property (run_w && grp_w == 3'h1 && op_w == 4'h1 && cc_w == 4'hf
    && instr_in[4:0] == 5'h00 |=> alu_result_reg_out == $past(xop_in - yop_in))
    else $error("x minus y wrong");
  chk_sub_yx: assert property (run_w && grp_w == 3'h1 && op_w == 4'h2 && cc_w == 4'hf
    && instr_in[4:0] == 5'h00 |=> alu_result_reg_out == $past(yop_in - xop_in))
    else $error("y minus x wrong");
  chk_never_skip: assert property (run_w && grp_w == 3'h1 && cc_w == 4'he |=>
    $stable(alu_result_reg_out) && $stable(alu_feedback_reg_out))
    else $error("false condition changed a result");
  chk_multi_refuse: assert property (run_w && grp_w == 3'h2
    && op_w inside {[4'hc:4'he]} |=> illegal_out && $stable(alu_result_reg_out) && !dm_rd_out
    && !dm_wr_out) else $error("refused multifunction had an effect");
  chk_dm_direct: assert property (run_w && grp_w == 3'h0 && instr_in[8]
    && !instr_in[7] && !instr_in[1] |=> dm_rd_out && dm_addr_out == $past(instr_in[13:0]))
    else $error("direct read address wrong");
  chk_pm_write: assert property (run_w && grp_w == 3'h0 && !instr_in[8]
    && instr_in[1] && instr_in[7] |=> pm_wr_out && !dm_wr_out
    && pm_wdata_out == {$past(xop_in), 8'h00})
    else $error("program memory write wrong");
  chk_wake_bound: assert property (s_sleep_irq |-> ##[1:200] !idle_out)
    else $error("no wake from wait");
  chk_idle_freeze: assert property (idle_out |=> $stable(alu_result_reg_out)
    && !dm_rd_out && !dm_wr_out) else $error("word executed while waiting");
endmodule // dci_core_properties

bind dci_core dci_core_properties #(.DW(DW), .AW(AW)) u_props (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in), .dm_rdata_in(dm_rdata_in),
  .pm_rdata_in(pm_rdata_in), .flag_pin_in(flag_pin_in), .irq_in(irq_in),
  .irq_vector_in(irq_vector_in), .xop_in(xop_in), .yop_in(yop_in), .pc_out(pc_out),
  .dm_addr_out(dm_addr_out), .dm_wdata_out(dm_wdata_out), .dm_rd_out(dm_rd_out),
  .dm_wr_out(dm_wr_out), .pm_addr_out(pm_addr_out), .pm_wdata_out(pm_wdata_out),
  .pm_rd_out(pm_rd_out), .pm_wr_out(pm_wr_out), .alu_result_reg_out(alu_result_reg_out),
  .alu_feedback_reg_out(alu_feedback_reg_out), .shift_result_out(shift_result_out),
  .group_out(group_out), .illegal_out(illegal_out), .idle_out(idle_out),
  .slow_tick_out(slow_tick_out));

// ===== tb/dci_core_tb_top.sv
// Self-checking bench for the instruction core
`timescale 1ns/100ps
module dci_core_tb_top;
  typedef struct {int s; logic [23:0] v; logic [13:0] p; logic [2:0] g;} dci_note_t;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, flag_pin_in = 1'b0, irq_in = 1'b0;
  logic [23:0] instr_in = 24'h80_0000, pm_rdata_in = 24'h00_0000;
  logic [15:0] dm_rdata_in, xop_in = 16'h0000, yop_in = 16'h0000, x, y;
  logic [13:0] irq_vector_in = 14'h0200, epc = 14'h0000, wpc;
  wire  [13:0] pc_out, dm_addr_out, pm_addr_out;
  wire  [15:0] dm_wdata_out, alu_result_reg_out, alu_feedback_reg_out, shift_result_out;
  wire  [23:0] pm_wdata_out;
  wire  [2:0]  group_out;
  wire         dm_rd_out, dm_wr_out, pm_rd_out, pm_wr_out, illegal_out, idle_out, slow_tick_out;
  int          mismatches = 0, n_checks = 0, i, j;
  dci_note_t   q[$], n;

  dci_core uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in), .dm_rdata_in(dm_rdata_in),
    .pm_rdata_in(pm_rdata_in), .flag_pin_in(flag_pin_in), .irq_in(irq_in),
    .irq_vector_in(irq_vector_in), .xop_in(xop_in), .yop_in(yop_in), .pc_out(pc_out),
    .dm_addr_out(dm_addr_out), .dm_wdata_out(dm_wdata_out), .dm_rd_out(dm_rd_out),
    .dm_wr_out(dm_wr_out), .pm_addr_out(pm_addr_out), .pm_wdata_out(pm_wdata_out),
    .pm_rd_out(pm_rd_out), .pm_wr_out(pm_wr_out), .alu_result_reg_out(alu_result_reg_out),
    .alu_feedback_reg_out(alu_feedback_reg_out), .shift_result_out(shift_result_out),
    .group_out(group_out), .illegal_out(illegal_out), .idle_out(idle_out),
    .slow_tick_out(slow_tick_out));

  // ==========================================
  // Clock, helpers and result monitor
  always #50 clk_in = ~clk_in;

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (e !== g) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Fields packed as group, op, condition, then the low thirteen bits
  function automatic logic [23:0] wd(input logic [2:0] g, input logic [3:0] o,
                                     input logic [3:0] c, input logic [12:0] f);
    return {g, o, c, f};
  endfunction

  // Reference arithmetic, kept apart from any design code
  function automatic logic [15:0] alu(input logic [3:0] o, input logic [15:0] a, input logic [15:0] b);
    case (o)
      4'h0: return a + b;
      4'h1: return a - b;
      4'h2: return b - a;
      4'h3: return a & b;
      4'h4: return a | b;
      4'h5: return a ^ b;
      4'h6: return a;
      4'h7: return -a;
      4'h8: return ~a;
      4'h9: return a[15] ? -a : a;
      4'ha: return b + 16'h0001;
      default: return b - 16'h0001;
    endcase
  endfunction

  // Words are driven on the falling edge; the note says what the next edge must show
  task automatic run(input logic [23:0] w, input int s, input logic [23:0] v, input logic [13:0] p);
    instr_in = w;
    q.push_back('{s, v, p, w[23:21]});
    epc = p;
    @(negedge clk_in);
  endtask

  // Oldest note against settled outputs, one note per word issued through run
  always @(posedge clk_in) begin
    if (q.size() > 0) begin
      #1 n = q.pop_front();
      chk("pc", n.p, pc_out);
      chk("group", n.g, group_out);
      case (n.s)
        1: chk("result", n.v, alu_result_reg_out);
        2: chk("feedback", n.v, alu_feedback_reg_out);
        3: chk("shift", n.v, shift_result_out);
        4: chk("dm read", {n.v[13:0], 1'b1}, {dm_addr_out, dm_rd_out});
        5: chk("refuse", {n.v[15:0], 1'b1}, {alu_result_reg_out, illegal_out});
        6: chk("pm write", {n.v[15:0], 1'b1}, {pm_wdata_out[23:8], pm_wr_out});
        7: chk("dm write", {n.v[13:0], 1'b1}, {dm_addr_out, dm_wr_out});
        8: chk("multi", {n.v[15:0], 2'b11}, {alu_result_reg_out, dm_rd_out, pm_rd_out});
        default: ;
      endcase
    end
  end

  // Watchdog: the whole sequence needs well under a tenth of this span
  initial begin
    #2_000_000;
    mismatches++;
    print_verdict;
  end

  // ==========================================
  // Main sequence
  initial begin
    x = $urandom(32'hf56c);
    dm_rdata_in = $urandom;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    chk("reset", 19'h0_0010, {pc_out, group_out, illegal_out, idle_out});
    rst_n_in = 1'b1;
    for (i = 0; i < 24; i++) begin
      x = $urandom;
      y = $urandom;
      {xop_in, yop_in} = {x, y};
      run(wd(1, i % 12, 15, 0), 1, alu(i % 12, x, y), epc + 1);
    end
    run(wd(1, 0, 15, 13'h0010), 2, alu(0, x, y), epc + 1);
    // Carry set or cleared by an add, then borrow form, then plain form ignoring carry
    for (i = 0; i < 4; i++) begin
      {xop_in, yop_in} = {i[0] ? 16'hffff : 16'h0001, 16'h0001};
      run(wd(1, 0, 15, 0), 1, i[0] ? 16'h0000 : 16'h0002, epc + 1);
      x = $urandom;
      y = $urandom;
      {xop_in, yop_in} = {x, y};
      // Cast keeps the borrow inside sixteen bits, as the register holds it
      run(wd(1, 1 + i[1], 15, 1), 1, 16'(alu(1 + i[1], x, y) - !i[0]),
          epc + 1);
      run(wd(1, 1 + i[1], 15, 0), 1, alu(1 + i[1], x, y), epc + 1);
    end
    // Zero flag set, then conditions false, true and never
    {xop_in, yop_in} = {16'hffff, 16'h0001};
    run(wd(1, 0, 15, 0), 1, 16'h0000, epc + 1);
    xop_in = x;
    run(wd(1, 6, 1, 0), 1, 16'h0000, epc + 1);
    run(wd(1, 6, 0, 0), 1, x, epc + 1);
    run(wd(1, 7, 14, 0), 1, x, epc + 1);
    {xop_in, yop_in} = {16'h1234, 16'h0005};
    run(wd(1, 14, 15, 13'h0003), 3, 16'h91a0, epc + 1);
    run(wd(1, 14, 15, 13'h00fe), 3, 16'h048d, epc + 1);
    run(wd(2, 15, 15, 0), 3, 16'h4680, epc + 1);
    // Second move also reads program memory, here through the same pointer 0
    run(wd(2, 1, 15, 13'h0008), 8, 16'h122f, epc + 1);
    for (i = 12; i < 15; i++) run(wd(2, i, 15, 0), 5, 16'h122f, epc + 1);
    // Pointer walk: modifier five, reads, writes, explicit modify, direct forms
    run(wd(4, 2, 0, 13'h0005), 0, 0, epc + 1);
    run(wd(0, 0, 0, 0), 4, 0, epc + 1);
    run(wd(0, 0, 0, 0), 4, 5, epc + 1);
    run(wd(0, 0, 0, 13'h0080), 7, 10, epc + 1);
    run(wd(4, 1, 0, 0), 0, 0, epc + 1);
    run(wd(0, 0, 0, 13'h0082), 6, xop_in, epc + 1);
    run(wd(0, 0, 0, 0), 4, 25, epc + 1);
    run(wd(0, 0, 0, 13'h0121), 4, 13'h0121, epc + 1);
    run(wd(0, 0, 0, 13'h01a1), 7, 13'h01a1, epc + 1);
    run(wd(3, 0, 15, 13'h0345), 0, 0, 14'h2345);
    run(wd(3, 0, 14, 13'h0345), 0, 0, epc + 1);
    wpc = epc + 1;
    run(wd(3, 1, 15, 13'h0100), 0, 0, 14'h2100);
    run(wd(3, 6, 15, 0), 0, 0, wpc);
    // Slow wait for every divisor, woken by the interrupt line
    for (i = 0; i < 4; i++) begin
      wpc = epc + 1;
      irq_vector_in = $urandom;
      instr_in = wd(3, 9, 15, {i[1:0], 11'h080});
      @(negedge clk_in);
      instr_in = 24'h80_0000;
      chk("idle", 1, idle_out);
      for (j = 0; j < 300 && slow_tick_out !== 1'b1; j++) @(negedge clk_in);
      @(negedge clk_in);
      for (j = 1; j < 300 && slow_tick_out !== 1'b1; j++) @(negedge clk_in);
      chk("divisor", 16 << i, j);
      irq_in = 1'b1;
      for (j = 0; j < 300 && idle_out !== 1'b0; j++) @(negedge clk_in);
      irq_in = 1'b0;
      chk("wake", {1'b0, irq_vector_in}, {idle_out, pc_out});
      run(wd(3, 7, 15, 0), 0, 0, wpc);
    end
    // Flag pin branches on both levels and both senses
    for (i = 0; i < 4; i++) begin
      flag_pin_in = i[0];
      repeat (3) run(wd(4, 0, 0, 0), 0, 0, epc + 1);
      run(wd(3, 4 + i[1], {3'h7, i[1]}, 13'h0300), 0, 0,
          (i[0] ^ i[1]) ? {i[1], 13'h0300} : epc + 1);
    end
    // Loop ends on a flow word so pc stepping checks stay valid there
    run(wd(3, 0, 15, 13'h0400), 0, 0, 14'h2400);
    run(wd(3, 8, 1, 13'h0402), 0, 0, 14'h2401);
    // Zero result repeats the body, nonzero meets the not-equal exit
    for (i = 0; i < 2; i++) begin
      {xop_in, yop_in} = {i[0] ? 16'h0001 : 16'hffff, 16'h0001};
      run(wd(1, 0, 15, 0), 1, i[0] ? 16'h0002 : 16'h0000, 14'h2402);
      run(wd(3, 6, 14, 0), 0, 0, i[0] ? 14'h2403 : 14'h2401);
    end
    repeat (2) @(negedge clk_in);
    print_verdict;
  end
endmodule // dci_core_tb_top
